// >>> hw/mrs_defines.vh
// What this block does
// - symbol rate is clock times (256 plus mantissa) times 2^exponent over 2^28
// - rates from 1.2 to 500 kBaud, step size doubling with each exponent
// - channel bandwidth is clock over 8 times (4 plus mantissa) times 2^exponent
// - channel filtering and offset compensation are digital; signal level gives strength
// - for frequency shift formats the offset estimate is readable in a status register
// - writing the estimate into the synth offset shifts the synthesizer to cancel it
// - tracking range is limited to plus or minus 16, 32 or 64 by the limit field, zero when the field is 0
// - with carrier sense gating set the estimate freezes until carrier sense asserts
// - loop gain uses the pre-sync setting before sync, post-sync setting after
// - no offset compensation for amplitude or on-off keying
// - bit sync recovers symbol clock at the programmed rate and resyncs continuously
// - transmit inserts the 16-bit sync word, optionally doubled to 32 bits
// - receive searches bits for sync word to set byte boundaries, stopping once found until a restart
// - with sync detection enabled only packets with matching sync word are accepted
// - match threshold is 15 of 16, 16 of 16, or 30 of 32 bits
// - with quality qualification a sync is accepted only if quality exceeds threshold
// - sync acceptance may also require carrier sense, alone or with quality
// - sync pattern comes from the high and low byte registers
// - sync modes 3 and 7 use the 16-bit word repeated to 32 bits
`ifndef MRS_DEFINES_VH
`define MRS_DEFINES_VH
`define MRS_ADDR_BW_RATE 8'h00
`define MRS_ADDR_RATE_LOW 8'h04
`define MRS_ADDR_SYNC_CFG 8'h08
`define MRS_ADDR_SYNC_HIGH 8'h0C
`define MRS_ADDR_SYNC_LOW 8'h10
`define MRS_ADDR_OFFSET_CFG 8'h14
`define MRS_ADDR_SYNTH_LOW 8'h18
`define MRS_ADDR_FREQ_EST 8'h1C
`define MRS_ADDR_CONTROL 8'h20
`define MRS_ADDR_STATUS 8'h24
`define MRS_ADDR_RSSI 8'h28
`define MRS_RST_BW_RATE 8'h8C
`define MRS_RST_RATE_LOW 8'h22
`define MRS_RST_SYNC_CFG 8'h02
`define MRS_RST_SYNC_HIGH 8'hD3
`define MRS_RST_SYNC_LOW 8'h91
`define MRS_RST_OFFSET_CFG 8'h36
`define MRS_RST_CONTROL 8'h00
`define MRS_MOD_ASK 3'h3
`define MRS_RATE_BASE 9'h100
`define MRS_BW_BASE 3'h4
`define MRS_ACC_W 28
`define MRS_ACC_HALF 28'h8000000
`define MRS_SYNC_MODE_NONE 2'h0
`define MRS_SYNC_MODE_15 2'h1
`define MRS_SYNC_MODE_16 2'h2
`define MRS_SYNC_MODE_30 2'h3
`define MRS_THR_15 6'h0F
`define MRS_THR_16 6'h10
`define MRS_THR_30 6'h1E
`define MRS_CTL_RESTART 0
`define MRS_CTL_PQI_EN 1
`define MRS_CTL_PQI_LSB 2
`endif

// >>> hw/mrs_modem_core.v
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "mrs_defines.vh"
module mrs_modem_core #(
    parameter SAMPLE_W = 8
) (
    input wire clock_in,
    input wire rst_n_in,
    input wire [7:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    output reg [7:0] reg_rdata_out,
    input wire [SAMPLE_W-1:0] rx_sample_in,
    input wire [7:0] rx_level_in,
    input wire carrier_sense_in,
    input wire [7:0] pqi_in,
    input wire tx_start_in,
    output reg symbol_tick_out,
    output reg tx_bit_out,
    output reg tx_active_out,
    output reg rx_bit_out,
    output reg rx_bit_valid_out,
    output reg [7:0] rx_byte_out,
    output reg rx_byte_valid_out,
    output reg sync_detect_out,
    output reg [7:0] synth_offset_out,
    output reg [7:0] rssi_out
);
    reg [7:0] bw_rate_reg;
    reg [7:0] rate_low_reg;
    reg [7:0] sync_cfg_reg;
    reg [7:0] sync_high_reg;
    reg [7:0] sync_low_reg;
    reg [7:0] offset_cfg_reg;
    reg [7:0] synth_low_reg;
    reg [7:0] control_reg;
    reg [7:0] freq_est_reg;
    reg sync_found_reg;

    wire [1:0] chan_bw_exponent = bw_rate_reg[7:6];
    wire [1:0] chan_bw_mantissa = bw_rate_reg[5:4];
    wire [3:0] rate_exponent = bw_rate_reg[3:0];
    wire [7:0] rate_mantissa = rate_low_reg;
    wire [2:0] mod_format = sync_cfg_reg[6:4];
    wire [1:0] sync_match_mode = sync_cfg_reg[1:0];
    wire sync_cs_required = sync_cfg_reg[2];
    wire offset_cs_gate = offset_cfg_reg[5];
    wire [1:0] offset_gain_pre_sync = offset_cfg_reg[4:3];
    wire offset_gain_post_sync = offset_cfg_reg[2];
    wire [1:0] offset_track_limit = offset_cfg_reg[1:0];
    wire [15:0] sync_word = {sync_high_reg, sync_low_reg};
    wire sync_long = (sync_match_mode == `MRS_SYNC_MODE_30);
    wire is_ask = (mod_format == `MRS_MOD_ASK);

    function [5:0] mrs_ones16;
        input [15:0] v;
        integer i;
        begin
            mrs_ones16 = 6'h00;
            for (i = 0; i < 16; i = i + 1) begin
                mrs_ones16 = mrs_ones16 + {5'h00, v[i]};
            end
        end
    endfunction

    // register write port
    always @(posedge clock_in) begin
        if (!rst_n_in) begin
            bw_rate_reg <= `MRS_RST_BW_RATE;
            rate_low_reg <= `MRS_RST_RATE_LOW;
            sync_cfg_reg <= `MRS_RST_SYNC_CFG;
            sync_high_reg <= `MRS_RST_SYNC_HIGH;
            sync_low_reg <= `MRS_RST_SYNC_LOW;
            offset_cfg_reg <= `MRS_RST_OFFSET_CFG;
            synth_low_reg <= 8'h00;
            control_reg <= `MRS_RST_CONTROL;
        end else begin
            control_reg[`MRS_CTL_RESTART] <= 1'b0;
            if (reg_wr_in) begin
                case (reg_addr_in)
                    `MRS_ADDR_BW_RATE: bw_rate_reg <= reg_wdata_in;
                    `MRS_ADDR_RATE_LOW: rate_low_reg <= reg_wdata_in;
                    `MRS_ADDR_SYNC_CFG: sync_cfg_reg <= {1'b0, reg_wdata_in[6:0]};
                    `MRS_ADDR_SYNC_HIGH: sync_high_reg <= reg_wdata_in;
                    `MRS_ADDR_SYNC_LOW: sync_low_reg <= reg_wdata_in;
                    `MRS_ADDR_OFFSET_CFG: offset_cfg_reg <= {2'b00, reg_wdata_in[5:0]};
                    `MRS_ADDR_SYNTH_LOW: synth_low_reg <= reg_wdata_in;
                    `MRS_ADDR_CONTROL: control_reg <= reg_wdata_in;
                    default: ;
                endcase
            end
        end
    end

    // read port: data one cycle after the strobe, zero for holes
    always @(posedge clock_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                `MRS_ADDR_BW_RATE: reg_rdata_out <= bw_rate_reg;
                `MRS_ADDR_RATE_LOW: reg_rdata_out <= rate_low_reg;
                `MRS_ADDR_SYNC_CFG: reg_rdata_out <= sync_cfg_reg;
                `MRS_ADDR_SYNC_HIGH: reg_rdata_out <= sync_high_reg;
                `MRS_ADDR_SYNC_LOW: reg_rdata_out <= sync_low_reg;
                `MRS_ADDR_OFFSET_CFG: reg_rdata_out <= offset_cfg_reg;
                `MRS_ADDR_SYNTH_LOW: reg_rdata_out <= synth_low_reg;
                `MRS_ADDR_FREQ_EST: reg_rdata_out <= freq_est_reg;
                `MRS_ADDR_CONTROL: reg_rdata_out <= {control_reg[7:1], 1'b0};
                `MRS_ADDR_STATUS: reg_rdata_out <= {6'h00, tx_active_out, sync_found_reg};
                `MRS_ADDR_RSSI: reg_rdata_out <= rssi_out;
                default: reg_rdata_out <= 8'h00;
            endcase
        end
    end

    // symbol rate accumulator; the system clock stands in for the crystal
    reg [`MRS_ACC_W-1:0] acc_reg;
    wire [`MRS_ACC_W-1:0] rate_inc = {19'h00000, `MRS_RATE_BASE + {1'b0, rate_mantissa}}
        << rate_exponent;
    wire [`MRS_ACC_W:0] acc_sum = {1'b0, acc_reg} + {1'b0, rate_inc};
    wire rate_wrap = acc_sum[`MRS_ACC_W];
    reg rx_sign_reg;
    wire rx_sign;
    wire rx_edge = rx_sign ^ rx_sign_reg;

    always @(posedge clock_in) begin
        if (!rst_n_in) begin
            acc_reg <= {`MRS_ACC_W{1'b0}};
            rx_sign_reg <= 1'b0;
            symbol_tick_out <= 1'b0;
        end else begin
            rx_sign_reg <= rx_sign;
            symbol_tick_out <= rate_wrap;
            // a symbol edge pulls the phase to mid-symbol so decisions sit at the eye centre
            if (rx_edge && !tx_active_out) begin
                acc_reg <= `MRS_ACC_HALF;
            end else begin
                acc_reg <= acc_sum[`MRS_ACC_W-1:0];
            end
        end
    end

    // boxcar channel filter; window length sets the bandwidth
    wire [9:0] win_len = {4'h0, `MRS_BW_BASE + {1'b0, chan_bw_mantissa}, 3'b000}
        << chan_bw_exponent;
    reg [9:0] win_cnt_reg;
    reg signed [17:0] fsum_reg;
    reg [17:0] lsum_reg;
    reg signed [SAMPLE_W-1:0] filt_reg;
    wire signed [SAMPLE_W+1:0] comp_sample = $signed({{2{rx_sample_in[SAMPLE_W-1]}}, rx_sample_in})
        - (is_ask ? 10'sd0 : $signed({{2{synth_low_reg[7]}}, synth_low_reg}));
    wire win_end = (win_cnt_reg >= win_len - 10'h001);
    wire [4:0] win_shift = 5'h05 + {3'b000, chan_bw_exponent};
    wire signed [17:0] fmean = fsum_reg >>> win_shift;
    wire [17:0] lmean = lsum_reg >> win_shift;

    always @(posedge clock_in) begin
        if (!rst_n_in) begin
            win_cnt_reg <= 10'h000;
            fsum_reg <= 18'sd0;
            lsum_reg <= 18'h00000;
            filt_reg <= {SAMPLE_W{1'b0}};
            rssi_out <= 8'h00;
        end else if (win_end) begin
            win_cnt_reg <= 10'h000;
            fsum_reg <= {{8{comp_sample[SAMPLE_W+1]}}, comp_sample};
            lsum_reg <= {10'h000, rx_level_in};
            // mean is approximate: the sum is divided by 32 times 2^exponent, the window length at mantissa 0
            filt_reg <= (fmean > 18'sd127) ? 8'sd127 : (fmean < -18'sd128) ? -8'sd128
                : fmean[SAMPLE_W-1:0];
            rssi_out <= (lmean > 18'd255) ? 8'hFF : lmean[7:0];
        end else begin
            win_cnt_reg <= win_cnt_reg + 10'h001;
            fsum_reg <= fsum_reg + {{8{comp_sample[SAMPLE_W+1]}}, comp_sample};
            lsum_reg <= lsum_reg + {10'h000, rx_level_in};
        end
    end

    // offset tracking loop
    wire [2:0] gain_shift = sync_found_reg ? {2'b01, offset_gain_post_sync} + 3'h1
        : {1'b0, offset_gain_pre_sync} + 3'h1;
    wire signed [9:0] est_err = $signed({filt_reg[7], filt_reg}) - $signed({freq_est_reg[7],
        freq_est_reg});
    wire signed [9:0] est_raw = $signed({{2{freq_est_reg[7]}}, freq_est_reg}) + (est_err >>> gain_shift);
    wire signed [9:0] est_lim = $signed({2'b00, 8'h08}) <<< offset_track_limit;
    wire est_freeze = (offset_cs_gate && !carrier_sense_in) || is_ask;
    reg signed [9:0] est_next;

    always @* begin
        est_next = est_raw;
        if (offset_track_limit == 2'b00) begin
            est_next = 10'sd0;
        end else if (est_raw > est_lim) begin
            est_next = est_lim;
        end else if (est_raw < -est_lim) begin
            est_next = -est_lim;
        end
    end

    always @(posedge clock_in) begin
        if (!rst_n_in) begin
            freq_est_reg <= 8'h00;
            synth_offset_out <= 8'h00;
        end else begin
            synth_offset_out <= synth_low_reg;
            if (win_end && !est_freeze) begin
                freq_est_reg <= est_next[7:0];
            end
        end
    end

    wire signed [SAMPLE_W+1:0] decide = comp_sample - (is_ask ? 10'sd0
        : $signed({{2{freq_est_reg[7]}}, freq_est_reg}));
    assign rx_sign = ~decide[SAMPLE_W+1];

    // receive: bit decision, sync search, byte framing
    reg [31:0] rx_shift_reg;
    reg [2:0] bit_cnt_reg;
    wire [31:0] rx_shift_next = {rx_shift_reg[30:0], rx_sign};
    wire [5:0] match_lo = mrs_ones16(~(rx_shift_next[15:0] ^ sync_word));
    wire [5:0] match_hi = mrs_ones16(~(rx_shift_next[31:16] ^ sync_word));
    reg corr_hit;

    always @* begin
        case (sync_match_mode)
            `MRS_SYNC_MODE_15: corr_hit = (match_lo >= `MRS_THR_15);
            `MRS_SYNC_MODE_16: corr_hit = (match_lo == `MRS_THR_16);
            `MRS_SYNC_MODE_30: corr_hit = (match_lo + match_hi >= `MRS_THR_30);
            default: corr_hit = 1'b0;
        endcase
    end

    wire pqi_ok = !control_reg[`MRS_CTL_PQI_EN]
        || (pqi_in[5:0] > control_reg[7:`MRS_CTL_PQI_LSB]);
    wire cs_ok = !sync_cs_required || carrier_sense_in;
    wire sync_accept = rate_wrap && !tx_active_out && !sync_found_reg && corr_hit
        && pqi_ok && cs_ok;
    wire no_sync = (sync_match_mode == `MRS_SYNC_MODE_NONE);
    wire framing = sync_found_reg || no_sync;

    always @(posedge clock_in) begin
        if (!rst_n_in) begin
            rx_shift_reg <= 32'h00000000;
            bit_cnt_reg <= 3'h0;
            sync_found_reg <= 1'b0;
            sync_detect_out <= 1'b0;
            rx_bit_out <= 1'b0;
            rx_bit_valid_out <= 1'b0;
            rx_byte_out <= 8'h00;
            rx_byte_valid_out <= 1'b0;
        end else begin
            sync_detect_out <= sync_accept;
            rx_bit_valid_out <= 1'b0;
            rx_byte_valid_out <= 1'b0;
            // a sync found in the same cycle as a restart is kept
            if (sync_accept) begin
                sync_found_reg <= 1'b1;
                bit_cnt_reg <= 3'h0;
            end else if (control_reg[`MRS_CTL_RESTART]) begin
                sync_found_reg <= 1'b0;
                bit_cnt_reg <= 3'h0;
            end else if (rate_wrap && !tx_active_out && framing) begin
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
                rx_byte_valid_out <= (bit_cnt_reg == 3'h7);
                if (bit_cnt_reg == 3'h7) begin
                    rx_byte_out <= rx_shift_next[7:0];
                end
            end
            if (rate_wrap && !tx_active_out) begin
                rx_shift_reg <= rx_shift_next;
                rx_bit_out <= rx_sign;
                rx_bit_valid_out <= framing;
            end
        end
    end

    // transmit: sync word sent MSB first, one bit per symbol tick
    reg [31:0] tx_shift_reg;
    reg [5:0] tx_left_reg;

    always @(posedge clock_in) begin
        if (!rst_n_in) begin
            tx_shift_reg <= 32'h00000000;
            tx_left_reg <= 6'h00;
            tx_active_out <= 1'b0;
            tx_bit_out <= 1'b0;
        end else if (tx_start_in && !tx_active_out) begin
            tx_shift_reg <= sync_long ? {sync_word, sync_word} : {sync_word, 16'h0000};
            tx_left_reg <= sync_long ? 6'h20 : 6'h10;
            tx_active_out <= 1'b1;
        end else if (tx_active_out && rate_wrap) begin
            if (tx_left_reg == 6'h00) begin
                tx_active_out <= 1'b0;
                tx_bit_out <= 1'b0;
            end else begin
                tx_bit_out <= tx_shift_reg[31];
                tx_shift_reg <= {tx_shift_reg[30:0], 1'b0};
                tx_left_reg <= tx_left_reg - 6'h01;
            end
        end
    end
endmodule
`default_nettype wire

// >>> hw/mrs_unused_guard.v
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// >>> dv/mrs_modem_props.sv
`timescale 1ns/10ps
`default_nettype none
module mrs_modem_props (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic tx_start_in,
    input wire logic symbol_tick_out,
    input wire logic tx_active_out,
    input wire logic sync_detect_out,
    input wire logic rx_byte_valid_out,
    input wire logic [7:0] synth_offset_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    rd_hold_a: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
        else $error("read data moved without a read");
    rd_unmapped_a: assert property (reg_rd_in && reg_addr_in == 8'h2C |=> reg_rdata_out == 8'h00)
        else $error("unmapped read not zero");
    cfg_top_a: assert property (reg_rd_in && reg_addr_in == 8'h08 |=> !reg_rdata_out[7])
        else $error("sync config bit 7 not zero");
    restart_clear_a: assert property (reg_rd_in && reg_addr_in == 8'h20 |=> !reg_rdata_out[0])
        else $error("restart bit reads back set");
    synth_follow_a: assert property (reg_wr_in && reg_addr_in == 8'h18 |-> ##2 synth_offset_out == $past(reg_wdata_in, 2))
        else $error("synth offset output does not follow write");
    tick_gap_a: assert property (symbol_tick_out |=> !symbol_tick_out [*8])
        else $error("symbol ticks too close");
    tx_start_a: assert property (tx_start_in && !tx_active_out |=> tx_active_out)
        else $error("transmit did not start");
    sync_pulse_a: assert property (sync_detect_out |=> !sync_detect_out)
        else $error("sync detect longer than one cycle");
    byte_gap_a: assert property (rx_byte_valid_out |=> !rx_byte_valid_out [*8])
        else $error("received bytes too close");
    sync_seen_c: cover property (sync_detect_out);
    byte_seen_c: cover property (rx_byte_valid_out);
    tx_seen_c: cover property ($rose(tx_active_out));
    synth_seen_c: cover property (reg_wr_in && reg_addr_in == 8'h18);
endmodule
bind mrs_modem_core mrs_modem_props i_props (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out),
    .tx_start_in(tx_start_in),
    .symbol_tick_out(symbol_tick_out),
    .tx_active_out(tx_active_out),
    .sync_detect_out(sync_detect_out),
    .rx_byte_valid_out(rx_byte_valid_out),
    .synth_offset_out(synth_offset_out)
);
`default_nettype wire

// >>> dv/mrs_far_tx.sv
`timescale 1ns/10ps
`default_nettype none
module mrs_far_tx #(
    parameter int SYM_CLKS = 64
) (
    input wire logic clock_in,
    output wire logic [7:0] sample_out,
    output wire logic [7:0] level_out
);
    logic signed [7:0] bias = 8'sh00;
    logic signed [7:0] sym = 8'sh00;
    // the carrier offset stays visible between frames, as on a real link
    assign sample_out = bias + sym;
    assign level_out = (sym != 8'sh00) ? 8'h60 : 8'h08;
    task automatic send(input logic [63:0] frame, input int nb);
        for (int i = nb - 1; i >= 0; i--) begin
            @(posedge clock_in);
            sym <= frame[i] ? 8'sh30 : -8'sh30;
            repeat (SYM_CLKS - 1) @(posedge clock_in);
        end
        @(posedge clock_in);
        sym <= 8'sh00;
    endtask
endmodule
`default_nettype wire

// >>> dv/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic clock_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [7:0] reg_addr_in = 8'h00;
    logic [7:0] reg_wdata_in = 8'h00;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic carrier_sense_in = 1'b0;
    logic [7:0] pqi_in = 8'h00;
    logic tx_start_in = 1'b0;
    wire logic [7:0] reg_rdata_out, rx_sample, rx_level, rx_byte_out, synth_offset_out, rssi_out;
    wire logic symbol_tick_out, tx_bit_out, tx_active_out, rx_byte_valid_out, sync_detect_out;
    int n_mismatch = 0, n_tests = 0, cycles = 0, n_sync = 0, nbyte = 0;
    logic [7:0] first_byte = 8'h00;
    logic [7:0] r_adr [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h20, 8'h2C};
    logic [7:0] r_val [8] = '{8'h8C, 8'h22, 8'h02, 8'hD3, 8'h91, 8'h36, 8'h00, 8'h00};
    logic [7:0] s_cfg [8] = '{8'h02, 8'h02, 8'h01, 8'h03, 8'h03, 8'h06, 8'h02, 8'h02};
    logic [7:0] s_ctl [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h2A, 8'h2A};
    logic [7:0] s_pqi [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h05, 8'h14};
    logic [31:0] s_word [8] = '{32'h0000D391, 32'h0000D390, 32'h0000D390, 32'hD391D391,
        32'hD391D390, 32'h0000D391, 32'h0000D391, 32'h0000D391};
    logic [7:0] s_cs = 8'hDF;
    logic [7:0] s_exp = 8'h9D;
    logic [7:0] s_long = 8'h18;
    always #10 clock_in = ~clock_in;
    mrs_far_tx i_far (.clock_in(clock_in), .sample_out(rx_sample), .level_out(rx_level));
    mrs_modem_core #(.SAMPLE_W(8)) i_dut (.clock_in(clock_in), .rst_n_in(rst_n_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .rx_sample_in(rx_sample),
        .rx_level_in(rx_level), .carrier_sense_in(carrier_sense_in), .pqi_in(pqi_in),
        .tx_start_in(tx_start_in), .symbol_tick_out(symbol_tick_out), .tx_bit_out(tx_bit_out),
        .tx_active_out(tx_active_out), .rx_bit_out(), .rx_bit_valid_out(),
        .rx_byte_out(rx_byte_out), .rx_byte_valid_out(rx_byte_valid_out),
        .sync_detect_out(sync_detect_out), .synth_offset_out(synth_offset_out),
        .rssi_out(rssi_out));
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge clock_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge clock_in);
        reg_rd_in <= 1'b0;
        #1 d = reg_rdata_out;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        check("reg_read", e, d);
    endtask
    // counts from one tick to the next; the first wait absorbs a partial period
    task automatic tick_gap(output int p);
        int g;
        g = 0;
        while (symbol_tick_out !== 1'b1 && g < 2000) begin
            @(negedge clock_in);
            g++;
        end
        p = 0;
        do begin
            @(negedge clock_in);
            p++;
        end while (symbol_tick_out !== 1'b1 && p < 2000);
    endtask
    always @(posedge clock_in) begin
        if (sync_detect_out === 1'b1) begin
            n_sync <= n_sync + 1;
            nbyte <= 0;
            // a missing byte after a sync must not pass on a stale capture
            first_byte <= 8'h00;
        end else if (rx_byte_valid_out === 1'b1 && nbyte == 0) begin
            first_byte <= rx_byte_out;
            nbyte <= 1;
        end
    end
    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            n_mismatch++;
            wrap_up;
        end
    end
    initial begin
        logic [7:0] d;
        logic [31:0] got;
        int p, n;
        repeat (4) @(posedge clock_in);
        rst_n_in <= 1'b1;
        for (int i = 0; i < 8; i++) rdc(r_adr[i], r_val[i]);
        wr(8'h1C, 8'hFF);
        rdc(8'h1C, 8'h00);
        wr(8'h04, 8'h00);
        // ends on exponent 14, a 64-clock symbol that the far transmitter uses
        for (int e = 15; e > 13; e--) begin
            wr(8'h00, 8'h80 | 8'(e));
            tick_gap(p);
            tick_gap(p);
            check("symbol_period", 1 << (20 - e), p);
        end
        for (int m = 2; m < 4; m++) begin
            wr(8'h08, 8'(m));
            @(posedge clock_in);
            tx_start_in <= 1'b1;
            @(posedge clock_in);
            tx_start_in <= 1'b0;
            got = 32'h0;
            n = 0;
            // a tick on the start edge carries no bit yet
            @(negedge clock_in);
            repeat (2600) begin
                @(negedge clock_in);
                if (symbol_tick_out === 1'b1) begin
                    repeat (32) @(negedge clock_in);
                    if (tx_active_out === 1'b1) begin
                        got = {got[30:0], tx_bit_out};
                        n++;
                    end
                end
            end
            check("tx_bits", (m == 3) ? 32 : 16, n);
            check("tx_word", (m == 3) ? 32'hD391D391 : 32'h0000D391, got);
        end
        i_far.bias <= 8'sd20;
        repeat (3000) @(posedge clock_in);
        rdc(8'h1C, 8'h00);
        carrier_sense_in <= 1'b1;
        repeat (3000) @(posedge clock_in);
        rd(8'h1C, d);
        check("est_positive", 1, d != 8'h00 && d[7] == 1'b0);
        wr(8'h08, 8'h32);
        i_far.bias <= -8'sd20;
        repeat (3000) @(posedge clock_in);
        rdc(8'h1C, d);
        wr(8'h18, d);
        @(posedge clock_in);
        #1 check("synth_offset", d, synth_offset_out);
        wr(8'h08, 8'h02);
        wr(8'h14, 8'h34);
        repeat (3000) @(posedge clock_in);
        rdc(8'h1C, 8'h00);
        rdc(8'h28, 8'h08);
        check("rssi", 8'h08, rssi_out);
        wr(8'h14, 8'h36);
        wr(8'h18, 8'h00);
        i_far.bias <= 8'sd0;
        for (int i = 0; i < 8; i++) begin
            wr(8'h08, s_cfg[i]);
            wr(8'h20, s_ctl[i] | 8'h01);
            carrier_sense_in <= s_cs[i];
            pqi_in <= s_pqi[i];
            n = n_sync;
            if (s_long[i])
                i_far.send({8'h00, 16'hAAAA, s_word[i], 8'h5A}, 56);
            else
                i_far.send({24'h000000, 16'hAAAA, s_word[i][15:0], 8'h5A}, 40);
            repeat (100) @(posedge clock_in);
            check("sync_count", {31'h0, s_exp[i]}, n_sync - n);
            if (s_exp[i])
                check("first_byte", 8'h5A, first_byte);
        end
        wrap_up;
    end
endmodule
`default_nettype wire
